/* File: include/scan_cfg.svh */
`ifndef SCAN_CFG_SVH
`define SCAN_CFG_SVH
// ==========================================================================
// register word indices on the avalon slave (byte address = index * 4)
`define SEG_BASE_IDX 4'h0
`define SEG_LAST_IDX 4'h9
`define CTRL_IDX 4'ha
`define STATUS_IDX 4'hb
`define KEYS_LO_IDX 4'hc
`define KEYS_HI_IDX 4'hd
// ==========================================================================
// control and status fields
`define CTRL_SCAN_EN_BIT 0
`define CTRL_RESET_VAL 1'b0
`define STATUS_STEP_LSB 0
`define STATUS_KEY_PHASE_BIT 8
`define STATUS_SCAN_EN_BIT 9
// ==========================================================================
// scan geometry
`define NUM_DIGIT_STEPS 10
`define NUM_KEY_ROWS 9
`define NUM_KEY_COLS 4
`define LAST_SCAN_STEP 5'd19
`define LAST_DIGIT_STEP 5'd9
`define FIRST_KEY_STEP 5'd10
`define CHAIN_W 16
`define LAST_ROW_COL_MASK 4'h1
// ==========================================================================
// timing: period and on time in ns, clock in MHz, step offsets in clock cycles
`define CLK_MHZ 250
`define SHIFT_PERIOD_NS 1000000
`define DIGIT_ON_NS 950000
`define SEG_AT 1
`define LOAD_AT 3
`define SAMPLE_BEFORE_END 2
`endif

/* File: include/scan_pkg.sv */
package scan_pkg;
  // one segment group: seven segments plus the spare line in bit 7
  typedef struct packed {
    logic spare;
    logic [6:0] seg;
  } seg_group_t;

  // the four latched groups that light one digit pair
  typedef struct packed {
    seg_group_t seg_group_four_bits;
    seg_group_t seg_group_three_bits;
    seg_group_t seg_group_two_bits;
    seg_group_t seg_group_one_bits;
  } seg_groups_t;

  typedef enum logic [0:0] {
    LAP_DISPLAY = 1'b0,
    LAP_KEYS = 1'b1
  } lap_t;
endpackage : scan_pkg

/* File: rtl/select_chain.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scan_cfg.svh"
module select_chain #(
  parameter int unsigned CHAIN_W = `CHAIN_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_shift_clk,
  input wire logic i_shift_data,
  input wire logic i_load,
  output logic [CHAIN_W-1:0] o_sel
);
  // ==========================================================================
  // two cascaded 8-bit stages, serial in, with a parallel holding stage
  logic shift_clk_prev_ff;
  logic [CHAIN_W-1:0] chain_ff;
  logic [CHAIN_W-1:0] sel_ff;

  // edge detect on the shift clock; the clock line is a plain level here
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_clk_prev_ff <= 1'b0;
    end else begin
      shift_clk_prev_ff <= i_shift_clk;
    end
  end

  // data bit taken on each rising shift clock edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chain_ff <= '0;
    end else if (i_shift_clk && !shift_clk_prev_ff) begin
      chain_ff <= {chain_ff[CHAIN_W-2:0], i_shift_data};
    end
  end

  // parallel outputs move only once the word is in, so no half-shifted
  // pattern ever reaches the digit drivers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_ff <= '0;
    end else if (i_load) begin
      sel_ff <= chain_ff;
    end
  end

  assign o_sel = sel_ff;
endmodule : select_chain
`default_nettype wire

/* File: rtl/led_display_keyboard_scanner.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scan_cfg.svh"
module led_display_keyboard_scanner #(
  parameter int unsigned STEP_CYC = `SHIFT_PERIOD_NS * `CLK_MHZ / 1000,
  parameter int unsigned ON_CYC = `DIGIT_ON_NS * `CLK_MHZ / 1000,
  parameter int unsigned CNT_W = 18
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // avalon-mm slave, word addressed
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // panel side
  output scan_pkg::seg_groups_t o_seg,
  output logic o_shift_clk,
  output logic o_shift_data,
  output logic [`NUM_DIGIT_STEPS-1:0] o_digit_sel,
  output logic [`NUM_KEY_ROWS-1:0] o_row_sel,
  input wire logic [`NUM_KEY_COLS-1:0] i_key_column_sense_lines
);
  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(STEP_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(STEP_CYC / 2);
  localparam logic [CNT_W-1:0] BLANK_CNT = CNT_W'(STEP_CYC - ON_CYC);
  localparam logic [CNT_W-1:0] SEG_CNT = CNT_W'(`SEG_AT);
  localparam logic [CNT_W-1:0] LOAD_CNT = CNT_W'(`LOAD_AT);
  localparam logic [CNT_W-1:0] SAMPLE_CNT = CNT_W'(STEP_CYC - `SAMPLE_BEFORE_END);

  // ==========================================================================
  // register storage
  scan_pkg::seg_groups_t seg_mem_ff [`NUM_DIGIT_STEPS];
  logic scan_en_ff;
  logic [`NUM_KEY_ROWS*`NUM_KEY_COLS-1:0] keys_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;

  // ==========================================================================
  // scan sequencer state
  logic [CNT_W-1:0] cnt_ff;
  logic [4:0] step_ff;
  logic shift_clk_ff;
  logic shift_data_ff;
  logic load_ff;
  scan_pkg::seg_groups_t seg_ff;
  logic [`NUM_DIGIT_STEPS-1:0] digit_sel_ff;
  logic [`NUM_KEY_ROWS-1:0] row_sel_ff;
  logic [`CHAIN_W-1:0] chain_sel;
  scan_pkg::lap_t lap;
  logic lit_window;
  logic [4:0] row_idx;
  logic bus_req;

  assign lap = (step_ff >= `FIRST_KEY_STEP) ? scan_pkg::LAP_KEYS : scan_pkg::LAP_DISPLAY;
  assign lit_window = scan_en_ff && (cnt_ff >= BLANK_CNT);
  assign row_idx = step_ff - `FIRST_KEY_STEP;
  assign bus_req = (i_avs_read || i_avs_write) && !ack_ff;

  // ==========================================================================
  // bus slave: waitrequest high on the first cycle, low on the second
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // read data is settled by the cycle in which waitrequest drops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
    end else if (bus_req && i_avs_read) begin
      if (i_avs_address <= `SEG_LAST_IDX) begin
        rdata_ff <= seg_mem_ff[i_avs_address];
      end else begin
        unique case (i_avs_address)
          `CTRL_IDX: rdata_ff <= 32'({scan_en_ff});
          `STATUS_IDX: rdata_ff <= 32'({scan_en_ff, lap, 3'h0, step_ff});
          `KEYS_LO_IDX: rdata_ff <= keys_ff[31:0];
          `KEYS_HI_IDX: rdata_ff <= 32'(keys_ff[35:32]);
          default: rdata_ff <= '0; // unmapped reads return zero
        endcase
      end
    end
  end

  // segment words per step: byte n is group n+1, bit 7 the annunciator line
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int s = 0; s < `NUM_DIGIT_STEPS; s++) begin
        seg_mem_ff[s] <= '0;
      end
    end else if (ack_ff && i_avs_write && i_avs_address <= `SEG_LAST_IDX) begin
      for (int b = 0; b < 4; b++) begin
        if (i_avs_byteenable[b]) begin
          seg_mem_ff[i_avs_address][8*b +: 8] <= i_avs_writedata[8*b +: 8];
        end
      end
    end
  end

  // scan enable; turning it off parks the sequencer at the first step
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scan_en_ff <= `CTRL_RESET_VAL;
    end else if (ack_ff && i_avs_write && i_avs_address == `CTRL_IDX && i_avs_byteenable[0]) begin
      scan_en_ff <= i_avs_writedata[`CTRL_SCAN_EN_BIT];
    end
  end

  // ==========================================================================
  // step timing: one shift clock period per select step
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
      step_ff <= '0;
    end else if (!scan_en_ff) begin
      cnt_ff <= '0;
      step_ff <= '0;
    end else if (cnt_ff == LAST_CNT) begin
      cnt_ff <= '0;
      step_ff <= (step_ff == `LAST_SCAN_STEP) ? 5'd0 : step_ff + 5'd1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // shift clock high for the first half of each step, so one edge per step
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_clk_ff <= 1'b0;
    end else begin
      shift_clk_ff <= scan_en_ff && (cnt_ff < HALF_CNT);
    end
  end

  // data changes mid-step while the clock is low; a one starts each lap
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_data_ff <= 1'b1;
    end else if (!scan_en_ff) begin
      shift_data_ff <= 1'b1;
    end else if (cnt_ff == HALF_CNT) begin
      shift_data_ff <= (step_ff == `LAST_DIGIT_STEP) || (step_ff == `LAST_SCAN_STEP);
    end
  end

  // word load strobe comes after the shift edge has been taken
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_ff <= 1'b0;
    end else begin
      load_ff <= scan_en_ff && (cnt_ff == LOAD_CNT);
    end
  end

  select_chain #(
    .CHAIN_W(`CHAIN_W)
  ) u_chain (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_shift_clk(shift_clk_ff),
    .i_shift_data(shift_data_ff),
    .i_load(load_ff),
    .o_sel(chain_sel)
  );

  // ==========================================================================
  // segment latches change early in the step while all selects are blanked
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_ff <= '0;
    end else if (!scan_en_ff) begin
      seg_ff <= '0;
    end else if (cnt_ff == SEG_CNT && lap == scan_pkg::LAP_DISPLAY) begin
      seg_ff <= seg_mem_ff[step_ff[3:0]];
    end
  end

  // digit pair lit only inside the on window; the blank gap hides shifting
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      digit_sel_ff <= '0;
    end else if (lit_window && lap == scan_pkg::LAP_DISPLAY) begin
      digit_sel_ff <= chain_sel[`NUM_DIGIT_STEPS-1:0];
    end else begin
      digit_sel_ff <= '0;
    end
  end

  // row drive reuses the low chain lines on the second lap
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      row_sel_ff <= '0;
    end else if (lit_window && lap == scan_pkg::LAP_KEYS) begin
      row_sel_ff <= chain_sel[`NUM_KEY_ROWS-1:0];
    end else begin
      row_sel_ff <= '0;
    end
  end

  // ==========================================================================
  // column sense sampled at the end of each row, once the row has settled
  for (genvar r = 0; r < `NUM_KEY_ROWS; r++) begin : g_row
    localparam logic [3:0] COL_MASK = (r == `NUM_KEY_ROWS - 1) ? `LAST_ROW_COL_MASK : 4'hf;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        keys_ff[4*r +: 4] <= '0;
      end else if (row_sel_ff[r] && cnt_ff == SAMPLE_CNT && row_idx == 5'(r)) begin
        keys_ff[4*r +: 4] <= i_key_column_sense_lines & COL_MASK;
      end
    end
  end

  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = !ack_ff;
  assign o_seg = seg_ff;
  assign o_shift_clk = shift_clk_ff;
  assign o_shift_data = shift_data_ff;
  assign o_digit_sel = digit_sel_ff;
  assign o_row_sel = row_sel_ff;
endmodule : led_display_keyboard_scanner
`default_nettype wire

/* File: testbench/scanner_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scan_cfg.svh"
// ==========================================================================
// panel and bus timing checks
module scanner_properties #(
  parameter int unsigned STEP_CYC = 40,
  parameter int unsigned ON_CYC = 30
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire scan_pkg::seg_groups_t o_seg,
  input wire logic o_shift_clk,
  input wire logic o_shift_data,
  input wire logic [`NUM_DIGIT_STEPS-1:0] o_digit_sel,
  input wire logic [`NUM_KEY_ROWS-1:0] o_row_sel,
  input wire logic [`NUM_KEY_COLS-1:0] i_key_column_sense_lines
);
  localparam int HIGH_M1 = STEP_CYC / 2 - 1;
  int lit_cnt_ff;
  logic [9:0] last_sel_ff;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // lit-time counter, cleared whenever every select is dark
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) lit_cnt_ff <= 0;
    else if (|o_digit_sel || |o_row_sel) lit_cnt_ff <= lit_cnt_ff + 1;
    else lit_cnt_ff <= 0;
  end
  // last lit digit, so the walking order can be judged across blanks
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) last_sel_ff <= 10'h000;
    else if (|o_digit_sel) last_sel_ff <= o_digit_sel;
  end
  a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("bus answer late");
  a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low too long");
  a_wait_idle: assert property (!(i_avs_read || i_avs_write) |-> o_avs_waitrequest) else $error("answer without request");
  a_sel_onehot: assert property ($onehot0({o_digit_sel, o_row_sel})) else $error("two selects lit");
  a_lit_time: assert property ($fell(|{o_digit_sel, o_row_sel}) |-> lit_cnt_ff == ON_CYC) else $error("lit time wrong");
  a_digit_walk: assert property ($rose(|o_digit_sel) |-> o_digit_sel == ((last_sel_ff == 10'h200 || last_sel_ff == 10'h000) ? 10'h001 : last_sel_ff << 1)) else $error("digit order wrong");
  a_rows_follow: assert property ($rose(o_row_sel[0]) |-> last_sel_ff == 10'h200) else $error("key lap out of place");
  a_clk_high: assert property ($rose(o_shift_clk) |-> ##HIGH_M1 o_shift_clk ##1 !o_shift_clk) else $error("shift clock high time wrong");
  a_data_quiet: assert property ($changed(o_shift_data) |-> !o_shift_clk) else $error("data moved while clock high");
  a_seg_hold: assert property (|o_digit_sel |-> $stable(o_seg)) else $error("segments moved while lit");
endmodule : scanner_properties
`default_nettype wire

/* File: testbench/key_matrix_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// key switch matrix seen through the row drivers
module key_matrix_model (
  input wire logic [8:0] i_row_sel,
  input wire logic [35:0] i_pressed,
  output logic [3:0] o_cols
);
  // columns float low through pull-downs when no row is driven
  always_comb begin
    o_cols = 4'h0;
    for (int r = 0; r < 8; r++) if (i_row_sel[r]) o_cols = o_cols | i_pressed[4*r +: 4];
    if (i_row_sel[8]) o_cols = o_cols | {3'h0, i_pressed[32]}; // only column one has a ninth row
  end
endmodule : key_matrix_model
`default_nettype wire

/* File: testbench/tb_led_display_keyboard_scanner.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scan_cfg.svh"
// ==========================================================================
// scanner bench
module tb_led_display_keyboard_scanner;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic waitreq;
  scan_pkg::seg_groups_t seg;
  logic [9:0] dsel;
  logic [8:0] rsel;
  logic [3:0] cols;
  logic sclk;
  logic sdat;
  logic [31:0] got;
  int mismatches = 0;
  int checks = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  led_display_keyboard_scanner #(.STEP_CYC(40), .ON_CYC(30), .CNT_W(8)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .o_seg(seg), .o_shift_clk(sclk), .o_shift_data(sdat),
    .o_digit_sel(dsel), .o_row_sel(rsel), .i_key_column_sense_lines(cols));
  // ninth row shows all columns pressed; only column one may get through
  key_matrix_model u_keys (.i_row_sel(rsel), .i_pressed(36'hf_8ce3_5a71), .o_cols(cols));
  task stop_test;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one bus cycle: request goes up just after a rising edge and holds until
  // waitrequest is sampled low at a rising edge; read data is taken and the
  // request dropped at that same edge, so the next call starts a cycle later
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    {adr, wd, be, rd, wr} <= {a, d, b, !w, w};
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    got = rdata;
    {rd, wr} <= 2'b00;
    if (waitreq !== 1'b0) begin
      mismatches++;
      stop_test();
    end
  endtask : bus
  task rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(got, exp);
  endtask : rchk
  task wait_sel(input logic row, input logic want);
    int n;
    n = 0;
    while (((row ? |rsel : |dsel) !== want) && n < 200) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_sel
  function automatic logic [31:0] pat(input int n);
    return (32'h10203040 + 32'h01010101 * 32'(n)) | ((n == 6) ? 32'h8000 : 32'h0);
  endfunction : pat
  // reset values, byte lanes, unmapped and read-only places
  task t_regs;
    rchk(4'h3, 32'h0);
    bus(1'b1, 4'h0, 32'h11223344, 4'hf);
    bus(1'b1, 4'h0, 32'haabbccdd, 4'h2);
    rchk(4'h0, 32'h1122cc44);
    bus(1'b1, 4'he, 32'hffffffff, 4'hf);
    rchk(4'he, 32'h0);
    bus(1'b1, `STATUS_IDX, 32'hffffffff, 4'hf);
    rchk(`STATUS_IDX, 32'h0);
  endtask : t_regs
  // display lap: order, pattern per pair, annunciator bit at step six
  task t_display;
    for (int n = 0; n < 10; n++) bus(1'b1, 4'(n), pat(n), 4'hf);
    bus(1'b1, `CTRL_IDX, 32'h1, 4'h1);
    bus(1'b0, `STATUS_IDX, 32'h0, 4'hf);
    chk({31'h0, got[`STATUS_SCAN_EN_BIT]}, 32'h1);
    for (int n = 0; n < 10; n++) begin
      wait_sel(1'b0, 1'b1);
      chk({22'h0, dsel}, 32'h1 << n);
      chk(seg, pat(n));
      chk({31'h0, sdat}, 32'(n == 0));
      wait_sel(1'b0, 1'b0);
    end
  endtask : t_display
  // key lap: rows one by one, then the captured columns
  task t_keys;
    for (int r = 0; r < 9; r++) begin
      wait_sel(1'b1, 1'b1);
      chk({23'h0, rsel}, 32'h1 << r);
      chk({31'h0, sdat}, 32'(r == 0));
      wait_sel(1'b1, 1'b0);
    end
    rchk(`KEYS_LO_IDX, 32'h8ce35a71);
    rchk(`KEYS_HI_IDX, 32'h1);
  endtask : t_keys
  // shift clock period, rise to rise, in reference cycles
  task t_period;
    int n;
    n = 0;
    while (sclk !== 1'b0 && n < 200) begin @(negedge i_ref_clk); n++; end
    while (sclk !== 1'b1 && n < 200) begin @(negedge i_ref_clk); n++; end
    n = 0;
    while (sclk !== 1'b0 && n < 200) begin @(negedge i_ref_clk); n++; end
    while (sclk !== 1'b1 && n < 200) begin @(negedge i_ref_clk); n++; end
    chk(32'(n), 32'd40);
  endtask : t_period
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    // reset state: segments dark, bus waiting, shift clock low, data high
    chk(seg, 32'h0);
    chk({28'h0, waitreq, sclk, sdat, |{dsel, rsel}}, 32'ha);
    t_regs();
    t_display();
    t_keys();
    t_period();
    stop_test();
  end
endmodule : tb_led_display_keyboard_scanner
bind led_display_keyboard_scanner scanner_properties #(.STEP_CYC(STEP_CYC), .ON_CYC(ON_CYC)) u_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_seg(o_seg), .o_shift_clk(o_shift_clk),
  .o_shift_data(o_shift_data), .o_digit_sel(o_digit_sel), .o_row_sel(o_row_sel),
  .i_key_column_sense_lines(i_key_column_sense_lines));
`default_nettype wire
